/* hdl/its_pkg.sv */
package its_pkg;

  // ==========================================================================
  // Register map (word offsets, index; byte address is twice the index)
  localparam logic [9:0] STOP_TASK_ID_IDX      = 10'h126;
  localparam logic [9:0] HANDLER_ERROR_IDX     = 10'h1aa;
  localparam logic [9:0] MAX_HANDLER_TIME_IDX  = 10'h1b8;
  localparam logic [9:0] LONGEST_HANDLER_IDX   = 10'h1b9;
  localparam logic [9:0] CONTROL_IDX           = 10'h000;
  localparam logic [9:0] PENDING_STATUS_IDX    = 10'h001;

  // ==========================================================================
  // Field layout and special values
  localparam int           TOP_BIT             = 15;
  localparam logic [15:0]  INT_TASK_MARK       = 16'h8000;
  localparam logic [15:0]  WORD_ZERO           = 16'h0000;
  localparam logic [7:0]   POWER_OFF_TASK      = 8'h01;
  localparam logic [7:0]   SCHED_TASK_LO       = 8'h02;
  localparam logic [7:0]   SCHED_TASK_HI       = 8'h03;
  localparam logic [7:0]   IO_TASK_LO          = 8'h64;
  localparam logic [7:0]   IO_TASK_HI          = 8'h83;
  localparam logic [6:0]   MAX_UNIT_NUMBER     = 7'h5f;
  localparam int           CTRL_RUN_BIT        = 0;
  localparam int           CTRL_DETECT_OFF_BIT = 1;
  localparam int           CTRL_PWROFF_EN_BIT  = 2;

  // ==========================================================================
  // Timing
  localparam int CLK_FREQ_HZ       = 10_000_000;
  localparam int TICK_TIME_US      = 100;
  localparam int TICK_CYCLES       = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
  localparam int LONG_RUN_TIME_MS  = 10;
  localparam int LONG_RUN_TICKS    = LONG_RUN_TIME_MS * 1000 / TICK_TIME_US;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_RUN      = 2'b01,
    ST_POWEROFF = 2'b11
  } its_state_type;

  typedef enum logic [1:0] {
    CLASS_IO    = 2'd0,
    CLASS_EXT   = 2'd1,
    CLASS_SCHED = 2'd2
  } its_class_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] task_num;
  } its_request_type;

  typedef struct packed {
    logic       valid;
    logic       is_dup;
    logic [7:0] number;
  } its_error_type;

  typedef struct packed {
    logic [9:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } its_bus_type;

endpackage : its_pkg

/* hdl/its_scheduler.sv */
// Contract
// R1 - External request any task 0-255, any time
// R2 - Serial board requests after memory written
// R3 - Requester names fixed or formula task number
// R4 - Shared number runs task on either trigger
// R5 - Power-off aborts running task, never resumed
// R6 - No nesting; pending waits for completion
// R7 - Clear command drops pending I/O only
// R8 - Dispatch I/O, then external, then scheduled
// R9 - Same type: lowest number first
// R10 - One record per task; none if running
// R11 - Longest handler time in 0.1 ms units
// R12 - Longest task word is 0x8000 plus number
// R13 - Top bit set at first interrupt
// R14 - Error flag only when detection enabled
// R15 - Over 10 ms: cause clear, task number
// R16 - Unit conflict: cause set, unit number
// R17 - Cyclic plus interrupt refresh is error
// R18 - Stop records interrupt or cyclic task
// R19 - Power-off task only when enabled
// R20 - Arbitrate once on each completion
`timescale 1ns/1ps
`default_nettype none

module its_scheduler
  import its_pkg::*;
#(
  parameter int NUM_TASKS = 256
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire its_pkg::its_bus_type     bus,
  output var  logic [15:0]              rdata,
  input  wire its_pkg::its_request_type ext_req,
  input  wire its_pkg::its_request_type io_req,
  input  wire its_pkg::its_request_type sched_req,
  input  wire logic                     power_loss,
  input  wire logic                     task_done,
  input  wire logic                     clear_pending_interrupt_cmd,
  input  wire logic                     slow_refresh_active,
  input  wire its_pkg::its_error_type   unit_conflict,
  input  wire logic                     program_error_stop,
  input  wire logic [4:0]               cyclic_task,
  output var  logic                     task_start,
  output var  logic [7:0]               task_id,
  output var  logic                     task_running,
  output var  logic                     cpu_reset,
  output var  logic                     handler_error_flag
);
  import its_pkg::*;

  // ==========================================================================
  // Power-loss input synchronisers
  // The pin is asynchronous to clk, so two flops come before any logic.
  // Only the rising edge counts: a supply that stays low must not keep
  // restarting the power-off task after it has finished.
  logic power_meta;
  logic power_sync;
  logic power_prev;

  always_ff @(posedge clk) begin
    if (srst) begin
      power_meta <= 1'b0;
      power_sync <= 1'b0;
      power_prev <= 1'b0;
    end else begin
      power_meta <= power_loss;
      power_sync <= power_meta;
      power_prev <= power_sync;
    end
  end

  wire power_event = power_sync & ~power_prev;

  // ==========================================================================
  // Control register
  // Start of operation is the 0 to 1 step of the run bit; writing the bit
  // high again while it is already high clears nothing.
  // Detection is enabled by a zero so that the reset value detects errors.
  logic [15:0] control;
  wire         run_mode     = control[CTRL_RUN_BIT];
  wire         detect_on    = ~control[CTRL_DETECT_OFF_BIT];
  wire         pwroff_en    = control[CTRL_PWROFF_EN_BIT];
  logic        run_prev;
  wire         start_op     = run_mode & ~run_prev;

  always_ff @(posedge clk) begin
    if (srst) begin
      control  <= WORD_ZERO;
      run_prev <= 1'b0;
    end else begin
      run_prev <= run_mode;
      if (bus.wr && bus.addr == CONTROL_IDX) begin
        control <= bus.wdata;
      end
    end
  end

  // ==========================================================================
  // Pending records, one bit per task and class
  // A single bit per task is all the memory there is: a second request for
  // a task already waiting is absorbed, so a fast scheduled source may lose
  // triggers while higher classes keep the sequencer busy.
  // Records are wiped when the power-off task takes over, since the CPU
  // resets afterwards and nothing queued may run.
  logic [NUM_TASKS-1:0] pend_io;
  logic [NUM_TASKS-1:0] pend_ext;
  logic [NUM_TASKS-1:0] pend_sched;
  its_state_type        state;
  logic [7:0]           running_id;
  logic                 dispatch;
  logic [7:0]           pick_id;
  its_class_type        pick_class;
  logic                 pick_valid;

  function automatic logic [NUM_TASKS-1:0] onehot(input logic [7:0] n);
    logic [NUM_TASKS-1:0] v;
    v    = '0;
    v[n] = 1'b1;
    return v;
  endfunction : onehot

  // Running task records nothing; set wins over dispatch clear
  function automatic logic [NUM_TASKS-1:0] set_mask(input its_request_type r,
                                                   input logic            busy,
                                                   input logic [7:0]      cur);
    logic [NUM_TASKS-1:0] v;
    v = '0;
    if (r.valid && !(busy && r.task_num == cur)) begin // see R10
      v = onehot(r.task_num);
    end
    return v;
  endfunction : set_mask

  wire busy = (state != ST_IDLE);

  always_ff @(posedge clk) begin
    if (srst || start_op || state == ST_POWEROFF) begin
      pend_io <= '0;
    end else begin
      pend_io <= (pend_io
                  & ~((dispatch && pick_class == CLASS_IO) ? onehot(pick_id) : '0)
                  & ~((clear_pending_interrupt_cmd && busy) ? '1 : '0)) // see R7
                 | set_mask(io_req, busy, running_id);
    end
  end

  always_ff @(posedge clk) begin
    if (srst || start_op || state == ST_POWEROFF) begin
      pend_ext <= '0;
    end else begin
      pend_ext <= (pend_ext
                   & ~((dispatch && pick_class == CLASS_EXT) ? onehot(pick_id) : '0))
                  | set_mask(ext_req, busy, running_id); // see R1
    end
  end

  always_ff @(posedge clk) begin
    if (srst || start_op || state == ST_POWEROFF) begin
      pend_sched <= '0;
    end else begin
      pend_sched <= (pend_sched
                     & ~((dispatch && pick_class == CLASS_SCHED) ? onehot(pick_id) : '0))
                    | set_mask(sched_req, busy, running_id);
    end
  end

  // ==========================================================================
  // Arbitration: class order, then lowest number
  // Each loop walks downward so the last hit is the lowest number; the
  // class loops run in reverse priority so the I/O loop has the last word.
  // This is a wide priority chain; it is only consulted when idle, so its
  // depth costs timing, not throughput.
  always_comb begin
    pick_valid = 1'b0;
    pick_id    = 8'h00;
    pick_class = CLASS_IO;
    for (int i = NUM_TASKS - 1; i >= 0; i--) begin // see R9
      if (pend_sched[i]) begin
        pick_valid = 1'b1;
        pick_id    = 8'(i);
        pick_class = CLASS_SCHED;
      end
    end
    for (int i = NUM_TASKS - 1; i >= 0; i--) begin
      if (pend_ext[i]) begin
        pick_valid = 1'b1;
        pick_id    = 8'(i);
        pick_class = CLASS_EXT;
      end
    end
    for (int i = NUM_TASKS - 1; i >= 0; i--) begin // see R8
      if (pend_io[i]) begin
        pick_valid = 1'b1;
        pick_id    = 8'(i);
        pick_class = CLASS_IO;
      end
    end
  end

  // A shared number simply runs the same task id, whichever class fired it
  assign dispatch = run_mode && pick_valid && state == ST_IDLE; // see R4 see R6 see R20

  // ==========================================================================
  // Task sequencer
  // Power-off is checked before completion, so a done pulse in the same
  // cycle as the power event still hands the sequencer to the power-off
  // task; the aborted task is never returned to.
  logic pwr_go;
  assign pwr_go = power_event && pwroff_en && run_mode; // see R19

  always_ff @(posedge clk) begin
    if (srst) begin
      state        <= ST_IDLE;
      running_id   <= 8'h00;
      task_start   <= 1'b0;
      task_id      <= 8'h00;
      task_running <= 1'b0;
      cpu_reset    <= 1'b0;
    end else begin
      task_start <= 1'b0;
      cpu_reset  <= 1'b0;
      case (state)
        ST_IDLE, ST_RUN: begin
          if (pwr_go) begin
            // Aborted task is dropped, not stacked
            state        <= ST_POWEROFF; // see R5
            running_id   <= POWER_OFF_TASK;
            task_id      <= POWER_OFF_TASK;
            task_start   <= 1'b1;
            task_running <= 1'b1;
          end else if (state == ST_RUN) begin
            if (task_done) begin // see R6
              state        <= ST_IDLE;
              task_running <= 1'b0;
            end
          end else if (dispatch) begin
            state        <= ST_RUN;
            running_id   <= pick_id;
            task_id      <= pick_id;
            task_start   <= 1'b1;
            task_running <= 1'b1;
          end
        end
        ST_POWEROFF: begin
          if (task_done) begin
            state        <= ST_IDLE;
            task_running <= 1'b0;
            cpu_reset    <= 1'b1; // see R5
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Handler timing in 0.1 ms ticks
  // The count saturates rather than wrapping, so a stuck handler never
  // reports as short. Time is measured from start to done, whole ticks only.
  logic [15:0] tick_div;
  logic [15:0] run_ticks;
  logic [15:0] max_handler_time_word;
  logic [15:0] longest_handler_id_word;
  wire         tick = (tick_div == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (srst || !busy) begin
      tick_div  <= '0;
      run_ticks <= '0;
    end else if (tick) begin
      tick_div  <= '0;
      run_ticks <= (run_ticks == '1) ? run_ticks : run_ticks + 16'd1;
    end else begin
      tick_div <= tick_div + 16'd1;
    end
  end

  wire handler_end = busy && task_done;

  always_ff @(posedge clk) begin
    if (srst || start_op) begin
      max_handler_time_word   <= WORD_ZERO; // see R11
      longest_handler_id_word <= WORD_ZERO; // see R13
    end else begin
      if (task_start) begin
        longest_handler_id_word[TOP_BIT] <= 1'b1; // see R13
      end
      if (handler_end && run_ticks > max_handler_time_word) begin
        max_handler_time_word   <= run_ticks; // see R11
        longest_handler_id_word <= INT_TASK_MARK | {8'h00, running_id}; // see R12
      end
    end
  end

  // ==========================================================================
  // Handler error reporting
  // A unit conflict outranks an overlong handler in the same cycle; the
  // info word keeps the latest report only. The overlong case reports once
  // per handler so the word is not rewritten every cycle.
  logic [15:0] handler_error_info_word;
  logic        long_reported;
  wire         too_long = busy && slow_refresh_active
                          && run_ticks > 16'(LONG_RUN_TICKS) && !long_reported;
  wire         dup_hit  = unit_conflict.valid && unit_conflict.number <= {1'b0, MAX_UNIT_NUMBER};

  always_ff @(posedge clk) begin
    if (srst || !busy) begin
      long_reported <= 1'b0;
    end else if (too_long) begin
      long_reported <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || start_op) begin
      handler_error_flag      <= 1'b0;
      handler_error_info_word <= WORD_ZERO;
    end else if (detect_on) begin // see R14
      if (dup_hit) begin
        handler_error_flag      <= 1'b1; // see R16 see R17
        handler_error_info_word <= INT_TASK_MARK | {8'h00, unit_conflict.number};
      end else if (too_long) begin
        handler_error_flag      <= 1'b1; // see R15
        handler_error_info_word <= {8'h00, running_id};
      end
    end
  end

  // ==========================================================================
  // Task recorded at program stop
  // Interrupt tasks carry the top mark; cyclic tasks are stored bare.
  logic [15:0] stop_task_id_word;

  always_ff @(posedge clk) begin
    if (srst || start_op) begin
      stop_task_id_word <= WORD_ZERO;
    end else if (program_error_stop) begin
      stop_task_id_word <= busy ? (INT_TASK_MARK | {8'h00, running_id}) // see R18
                                : {11'h000, cyclic_task};
    end
  end

  // ==========================================================================
  // Register read port, data one cycle after the strobe
  // Idle cycles return zero so a stale word is never mistaken for a read.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= WORD_ZERO;
    end else if (bus.rd) begin
      case (bus.addr)
        STOP_TASK_ID_IDX:     rdata <= stop_task_id_word;
        HANDLER_ERROR_IDX:    rdata <= handler_error_info_word;
        MAX_HANDLER_TIME_IDX: rdata <= max_handler_time_word;
        LONGEST_HANDLER_IDX:  rdata <= longest_handler_id_word;
        CONTROL_IDX:          rdata <= control;
        PENDING_STATUS_IDX:   rdata <= {11'h000, handler_error_flag, cpu_reset,
                                        task_running, |pend_ext, |pend_io};
        default:              rdata <= WORD_ZERO;
      endcase
    end else begin
      rdata <= WORD_ZERO;
    end
  end

endmodule : its_scheduler

`default_nettype wire

/* bench/its_scheduler_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module its_scheduler_checker #(
  parameter int NUM_TASKS = 256
) (
  input wire logic                   clk,
  input wire logic                   srst,
  input wire its_pkg::its_bus_type   bus,
  input wire logic [15:0]            rdata,
  input wire logic                   power_loss,
  input wire logic                   task_done,
  input wire logic                   slow_refresh_active,
  input wire its_pkg::its_error_type unit_conflict,
  input wire logic                   task_start,
  input wire logic [7:0]             task_id,
  input wire logic                   task_running,
  input wire logic                   cpu_reset,
  input wire logic                   handler_error_flag
);
  import its_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ======
  // Dispatch
  AST_START_ONE:
    assert property (task_start |-> task_running ##1 !task_start) else $error("bad start");
  AST_NO_NEST:
    assert property (task_start && task_id != POWER_OFF_TASK |-> !$past(task_running))
    else $error("nested start");
  AST_RUN_HOLD:
    assert property (task_running && !task_done |=> task_running) else $error("run lost");
  AST_DONE_GAP:
    assert property (task_done && task_running && !power_loss |=> !task_running && !task_start)
    else $error("no gap after done");
  AST_PWR_PREEMPT:
    assert property (task_start && $past(task_running) |->
      task_id == POWER_OFF_TASK && $past(power_loss, 2)) else $error("bad preempt");
  AST_CPU_RESET:
    assert property (cpu_reset |-> !$past(cpu_reset) && ($past(task_done) ||
      $past(task_done, 2))) else $error("cpu reset w/o done");
  // ======
  // Errors and reads
  AST_FLAG_HOLD:
    assert property (handler_error_flag && !bus.wr && !$past(bus.wr) |=> handler_error_flag)
    else $error("flag dropped");
  AST_FLAG_CAUSE:
    assert property ($rose(handler_error_flag) |-> $past(unit_conflict.valid) ||
      $past(unit_conflict.valid, 2) || $past(slow_refresh_active)) else $error("flag no cause");
  AST_RD_IDLE:
    assert property (!$past(bus.rd) |-> rdata == WORD_ZERO) else $error("rdata not idle");
endmodule : its_scheduler_checker
`default_nettype wire

/* bench/its_requester.sv */
`timescale 1ns/1ps
`default_nettype none
module its_requester #(
  parameter logic       FIXED_MODE = 1'b0,
  parameter logic [7:0] FIXED_TASK = 8'h00
) (
  input wire logic                     clk,
  input wire logic                     data_written,
  input wire logic [7:0]               case_task,
  output var its_pkg::its_request_type ext_req
);
  import its_pkg::*;
  // Request only once received data sits in memory; number otherwise churns
  always_ff @(posedge clk) begin
    ext_req.valid    <= data_written;
    ext_req.task_num <= !data_written ? ~ext_req.task_num :
                        FIXED_MODE ? FIXED_TASK : case_task;
  end
endmodule : its_requester
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
  import its_pkg::*;
  logic            clk = 0, srst = 1, pwr = 0, done = 0, clr = 0, stop = 0, wrt = 0;
  logic            start, running, cpu_rst, flag;
  its_bus_type     bus = '0;
  its_request_type ext_req, io_req = '0, sched_req = '0;
  its_error_type   conflict = '{1'b0, 1'b1, 8'h5f};
  logic [4:0]      cyc = '0;
  logic [7:0]      num = '0, id;
  logic [15:0]     rdata, v;
  int              n_errors = 0, n_compared = 0;
  initial forever #50 clk = ~clk;
  its_requester its_requester_inst (.clk(clk), .data_written(wrt), .case_task(num),
    .ext_req(ext_req));
  its_scheduler its_scheduler_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
    .ext_req(ext_req), .io_req(io_req), .sched_req(sched_req), .power_loss(pwr),
    .task_done(done), .clear_pending_interrupt_cmd(clr), .slow_refresh_active(1'b0),
    .unit_conflict(conflict), .program_error_stop(stop), .cyclic_task(cyc),
    .task_start(start), .task_id(id), .task_running(running), .cpu_reset(cpu_rst),
    .handler_error_flag(flag));
  // ======
  // Bus and stimulus helpers
  task automatic results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic acc(input logic [9:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    bus <= '{a, d, w, !w};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask : acc
  task automatic req(input its_class_type k, input logic [7:0] n);
    @(posedge clk);
    case (k)
      CLASS_IO: io_req <= '{1'b1, n};
      CLASS_EXT: {wrt, num} <= {1'b1, n};
      default: sched_req <= '{1'b1, n};
    endcase
    @(posedge clk);
    {io_req, sched_req, wrt} <= '0;
  endtask : req
  task automatic hit(input int s);
    @(posedge clk);
    case (s)
      0: done <= 1'b1;
      1: clr <= 1'b1;
      2: stop <= 1'b1;
      default: conflict.valid <= 1'b1;
    endcase
    @(posedge clk);
    {done, clr, stop, conflict.valid} <= '0;
  endtask : hit
  task automatic want(input logic [7:0] t);
    int i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while (start !== 1'b1 && i < 60);
    if (i == 60) begin
      n_errors++;
      results();
    end
    `CHK(id, t)
  endtask : want
  task automatic quiet;
    repeat (30) begin
      @(posedge clk);
      #1 `CHK(start, 1'b0)
    end
  endtask : quiet
  task automatic run(input logic [15:0] c);
    acc(CONTROL_IDX, 16'h0, 1);
    acc(CONTROL_IDX, c, 1);
  endtask : run
  // ======
  // Scenarios
  task automatic t_time;
    run(16'h1);
    acc(MAX_HANDLER_TIME_IDX, 0, 0);
    `CHK(v, WORD_ZERO)
    acc(LONGEST_HANDLER_IDX, 0, 0);
    `CHK(v, WORD_ZERO)
    acc(10'h3ff, 0, 0);
    `CHK(v, WORD_ZERO)
    req(CLASS_EXT, 8'h22);
    want(8'h22);
    repeat (2500) @(posedge clk);
    hit(0);
    acc(MAX_HANDLER_TIME_IDX, 0, 0);
    `CHK(v[15:1], 15'h1)
    req(CLASS_EXT, 8'hff);
    want(8'hff);
    hit(0);
    acc(LONGEST_HANDLER_IDX, 0, 0);
    `CHK(v, 16'h8022)
    $display("time test done");
  endtask : t_time
  task automatic t_prio;
    logic [7:0] ord [5] = '{8'h65, 8'h70, 8'h07, 8'h09, 8'h02};
    req(CLASS_EXT, 8'h05);
    want(8'h05);
    req(CLASS_SCHED, 8'h02);
    req(CLASS_EXT, 8'h09);
    req(CLASS_EXT, 8'h09);
    req(CLASS_EXT, 8'h05);
    req(CLASS_IO, 8'h70);
    req(CLASS_IO, 8'h65);
    req(CLASS_EXT, 8'h07);
    hit(0);
    foreach (ord[i]) begin
      want(ord[i]);
      hit(0);
    end
    quiet();
    $display("priority test done");
  endtask : t_prio
  task automatic t_clear;
    req(CLASS_EXT, 8'h50);
    want(8'h50);
    req(CLASS_IO, 8'h66);
    req(CLASS_EXT, 8'h0a);
    hit(1);
    hit(0);
    want(8'h0a);
    hit(0);
    quiet();
    $display("clear test done");
  endtask : t_clear
  task automatic t_stop;
    req(CLASS_EXT, 8'h44);
    want(8'h44);
    hit(2);
    acc(STOP_TASK_ID_IDX, 0, 0);
    `CHK(v, 16'h8044)
    hit(0);
    cyc <= 5'h1f;
    hit(2);
    acc(STOP_TASK_ID_IDX, 0, 0);
    `CHK(v, 16'h001f)
    $display("stop test done");
  endtask : t_stop
  task automatic t_err(input logic [15:0] c, input logic f);
    run(c);
    req(CLASS_EXT, 8'h40);
    want(8'h40);
    hit(3);
    hit(0);
    acc(HANDLER_ERROR_IDX, 0, 0);
    `CHK(flag, f)
    if (f) `CHK(v, 16'h805f)
    $display("error test done");
  endtask : t_err
  task automatic t_power;
    int i;
    run(16'h1);
    pwr <= 1'b1;
    quiet();
    pwr <= 1'b0;
    run(16'h5);
    req(CLASS_EXT, 8'h30);
    want(8'h30);
    req(CLASS_EXT, 8'h31);
    pwr <= 1'b1;
    want(POWER_OFF_TASK);
    hit(0);
    #1;
    for (i = 0; i < 10 && cpu_rst !== 1'b1; i++) @(posedge clk) #1;
    `CHK(cpu_rst, 1'b1)
    quiet();
    $display("power test done");
  endtask : t_power
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_time();
    t_prio();
    t_clear();
    t_stop();
    t_err(16'h1, 1'b1);
    t_err(16'h3, 1'b0);
    t_power();
    results();
  end
endmodule : testbench
bind its_scheduler its_scheduler_checker #(.NUM_TASKS(NUM_TASKS)) its_scheduler_checker_inst (
  .clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .power_loss(power_loss),
  .task_done(task_done), .slow_refresh_active(slow_refresh_active),
  .unit_conflict(unit_conflict), .task_start(task_start), .task_id(task_id),
  .task_running(task_running), .cpu_reset(cpu_reset), .handler_error_flag(handler_error_flag));
`default_nettype wire
